// *** regu_defines.vh ***
`ifndef REGU_DEFINES_VH
`define REGU_DEFINES_VH
// command codes
`define CMD_RUN 8'h01
`define CMD_ONSRC 8'h02
`define CMD_CLRFLT 8'h03
`define CMD_GUARD 8'h10
`define CMD_STORE 8'h15
`define CMD_RESTORE 8'h16
`define CMD_FEAT 8'h19
`define CMD_AMASK 8'h1B
`define CMD_SETPT 8'h21
`define CMD_TRIM 8'h22
`define CMD_CEIL 8'h24
`define CMD_MHI 8'h25
`define CMD_MLO 8'h26
`define CMD_SLEW 8'h27
`define CMD_SCALE 8'h29
`define CMD_FSW 8'h33
`define CMD_VINON 8'h35
`define CMD_VINOFF 8'h36
`define CMD_IOFS 8'h39
`define CMD_OVF 8'h40
`define CMD_OVACT 8'h41
`define CMD_OVW 8'h42
// register slots in the user store
`define NREG 19
`define S_RUN 5'h00
`define S_ONSRC 5'h01
`define S_GUARD 5'h02
`define S_AMASK 5'h03
`define S_SETPT 5'h04
`define S_TRIM 5'h05
`define S_CEIL 5'h06
`define S_MHI 5'h07
`define S_MLO 5'h08
`define S_SLEW 5'h09
`define S_SCALE 5'h0A
`define S_FSW 5'h0B
`define S_VINON 5'h0C
`define S_VINOFF 5'h0D
`define S_IOFS 5'h0E
`define S_OVF 5'h0F
`define S_OVACT 5'h10
`define S_OVW 5'h11
`define S_NONE 5'h1F
// reset values; output voltages in 1/512 V linear16, slew, scale, frequency, input and current levels linear11, control bytes and mask raw bits
`define D_RUN 16'h0080
`define D_ONSRC 16'h0016
`define D_GUARD 16'h0000
`define D_AMASK 16'h0000
`define D_SETPT 16'h0200
`define D_TRIM 16'h0000
`define D_CEIL 16'h0400
`define D_MHI 16'h0219
`define D_MLO 16'h01E6
`define D_SLEW 16'hE002
`define D_SCALE 16'hE808
`define D_FSW 16'h03D2
`define D_VINON 16'hF810
`define D_VINOFF 16'hF80E
`define D_IOFS 16'h0000
`define D_OVF 16'h02CB
`define D_OVACT 16'h0080
`define D_OVW 16'h029A
// field positions and codes
`define FEAT_VAL 8'hB0
`define MARG_MSB 5
`define MARG_LSB 4
`define MARG_LOW 2'h1
`define MARG_HIGH 2'h2
`define ON_BIT 7
`define OVACT_SHUT_BIT 7
`define GUARD_ALL 8'h80
`define GUARD_SOME 8'h40
`define GUARD_RUNONLY 8'h20
// linear11 field layout
`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define EXP_M1 5'h1F
`define EXP_M3 5'h1D
`define EXP_M4 5'h1C
`define EXP_1 5'h01
`define EXP_0 5'h00
`define FSW_MIN 11'd166
`define FSW_MAX 11'd1500
`define FSW_MIN_E1 11'd83
`define FSW_MAX_E1 11'd750
`endif

// *** cmd_table.v ***
`timescale 1ns/1ps
`include "regu_defines.vh"
// maps a command code to its store slot and size
module cmd_table (
  input wire [7:0] code,
  output reg [4:0] slot,
  output reg is_word,
  output reg is_send
);
  // pure decode, shared by write and read paths
  always @* begin
    slot = `S_NONE;
    is_word = 1'b1;
    is_send = 1'b0;
    case (code)
      `CMD_RUN: begin slot = `S_RUN; is_word = 1'b0; end
      `CMD_ONSRC: begin slot = `S_ONSRC; is_word = 1'b0; end
      `CMD_GUARD: begin slot = `S_GUARD; is_word = 1'b0; end
      `CMD_OVACT: begin slot = `S_OVACT; is_word = 1'b0; end
      `CMD_FEAT: is_word = 1'b0;
      `CMD_CLRFLT, `CMD_STORE, `CMD_RESTORE: begin is_send = 1'b1; is_word = 1'b0; end
      `CMD_AMASK: slot = `S_AMASK;
      `CMD_SETPT: slot = `S_SETPT;
      `CMD_TRIM: slot = `S_TRIM;
      `CMD_CEIL: slot = `S_CEIL;
      `CMD_MHI: slot = `S_MHI;
      `CMD_MLO: slot = `S_MLO;
      `CMD_SLEW: slot = `S_SLEW;
      `CMD_SCALE: slot = `S_SCALE;
      `CMD_FSW: slot = `S_FSW;
      `CMD_VINON: slot = `S_VINON;
      `CMD_VINOFF: slot = `S_VINOFF;
      `CMD_IOFS: slot = `S_IOFS;
      `CMD_OVF: slot = `S_OVF;
      `CMD_OVW: slot = `S_OVW;
      default: is_word = 1'b0;
    endcase
  end
endmodule // cmd_table

// *** vout_target.v ***
`timescale 1ns/1ps
`include "regu_defines.vh"
// picks nominal or margin target, adds trim, clamps to ceiling
module vout_target (
  input wire [15:0] setpoint,
  input wire [15:0] trim,
  input wire [15:0] margin_hi,
  input wire [15:0] margin_lo,
  input wire [15:0] ceiling,
  input wire [1:0] margin_sel,
  output reg [15:0] target
);
  reg [15:0] base;
  reg [16:0] sum;
  // trim is signed; negative results floor at zero
  always @* begin
    case (margin_sel)
      `MARG_HIGH: base = margin_hi;
      `MARG_LOW: base = margin_lo;
      default: base = setpoint;
    endcase
    sum = {1'b0, base} + {trim[15], trim};
    if (trim[15] && sum[16])
      target = 16'h0000;
    else if (sum[16] || sum[15:0] > ceiling)
      target = ceiling;
    else
      target = sum[15:0];
  end
endmodule // vout_target

// *** pmbus_command_set.v ***
`timescale 1ns/1ps
`include "regu_defines.vh"
// Overview of operation
// - clear-faults send byte clears latched faults
// - store command burns user registers to otp
// - restore command reloads user registers from otp
// - capability read returns 1011 upper nibble
// - write guard byte blocks later writes
// - alert mask word, read back, gates alerts
// - run control byte: on/off and margin select
// - turn-on source config byte
// - output setpoint word, default 1 V
// - ceiling clamps every commanded output voltage
// - margin high/low targets used when selected
// - slew rate, exponents 0 to -4 only
// - scale factor only 1,.5,.25,.125 exp -3
// - switching frequency 166 to 1500 kHz
// - input start threshold, default 8 V
// - input stop threshold, default 7 V
// - signed current offset, default zero
// - overvoltage fault level, default 1.396 V
// - overvoltage action ignore or shutdown
// - overvoltage warning level, default 1.301 V
// - user trim added to commanded voltage
// - registers reachable by plain and pmbus transfers
// - alert response, timeout, group commands upstream
//
// the bus engine upstream frames transactions (pec, ara, timeout, group)
// and hands over one byte at a time; this block only interprets commands.
module pmbus_command_set #(
  parameter NREG = `NREG
) (
  input wire ref_clk,
  input wire rst_b,
  input wire frame_start, // pulse: new transaction begins
  input wire code_valid, // pulse: command code byte
  input wire [7:0] code_byte,
  input wire data_valid, // pulse: written data byte
  input wire [7:0] data_byte,
  input wire frame_stop, // pulse: transaction ended cleanly
  input wire rd_req, // pulse: host wants a read byte
  input wire [15:0] fault_events, // hardware fault sets
  input wire otp_done, // pulse: otp burn finished
  input wire [15:0] otp_rdata, // otp word for otp_addr
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg [15:0] fault_latch,
  output reg [15:0] alert_active,
  output reg otp_burn,
  output reg [4:0] otp_addr,
  output reg [15:0] otp_wdata,
  output reg otp_we,
  output reg busy,
  output reg cmd_error,
  output reg conv_on,
  output reg [15:0] vout_goal,
  output reg [7:0] onsrc_cfg,
  output reg [15:0] slew_cfg,
  output reg [15:0] scale_cfg,
  output reg [15:0] fsw_cfg,
  output reg [15:0] vin_on_cfg,
  output reg [15:0] vin_off_cfg,
  output reg [15:0] iout_ofs_cfg,
  output reg [15:0] ov_fault_cfg,
  output reg ov_shutdown,
  output reg [15:0] ov_warn_cfg
);
  // one-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_STORE = 3'b010;
  localparam ST_LOAD = 3'b100;

  // user store and frame/sequencer state
  reg [15:0] regs [0:NREG-1]; // user register store
  reg [2:0] state;
  reg [7:0] code; // latched command code
  reg [1:0] nbytes; // data bytes seen this frame
  reg [7:0] lo_byte; // low byte held until high arrives
  reg rd_hi; // next read byte is high half
  reg [4:0] seq_cnt; // store/restore slot walker
  // decoded view of the latched code
  wire [4:0] slot;
  wire is_word;
  wire is_send;
  wire [15:0] goal;
  // assembled word: the high byte arrives last, the low byte is held
  wire [15:0] wr_word = {data_byte, lo_byte};

  // default of each slot, used at reset
  function [15:0] dflt;
    input [4:0] s;
    begin
      case (s)
        `S_RUN: dflt = `D_RUN;
        `S_ONSRC: dflt = `D_ONSRC;
        `S_GUARD: dflt = `D_GUARD;
        `S_AMASK: dflt = `D_AMASK;
        `S_SETPT: dflt = `D_SETPT;
        `S_TRIM: dflt = `D_TRIM;
        `S_CEIL: dflt = `D_CEIL;
        `S_MHI: dflt = `D_MHI;
        `S_MLO: dflt = `D_MLO;
        `S_SLEW: dflt = `D_SLEW;
        `S_SCALE: dflt = `D_SCALE;
        `S_FSW: dflt = `D_FSW;
        `S_VINON: dflt = `D_VINON;
        `S_VINOFF: dflt = `D_VINOFF;
        `S_IOFS: dflt = `D_IOFS;
        `S_OVF: dflt = `D_OVF;
        `S_OVACT: dflt = `D_OVACT;
        `S_OVW: dflt = `D_OVW;
        default: dflt = 16'h0000;
      endcase
    end
  endfunction

  // range checks on linear-format words; bad values are refused
  function legal;
    input [4:0] s;
    input [15:0] w;
    begin
      case (s)
        `S_SLEW: legal = (w[`EXP_MSB:`EXP_LSB] == `EXP_0) ||
          (w[`EXP_MSB:`EXP_LSB] >= `EXP_M4);
        `S_SCALE: legal = (w[`EXP_MSB:`EXP_LSB] == `EXP_M3) &&
          (w[`MAN_MSB:0] == 11'd8 || w[`MAN_MSB:0] == 11'd4 ||
          w[`MAN_MSB:0] == 11'd2 || w[`MAN_MSB:0] == 11'd1);
        `S_FSW: legal = ((w[`EXP_MSB:`EXP_LSB] == `EXP_0) &&
          w[`MAN_MSB:0] >= `FSW_MIN && w[`MAN_MSB:0] <= `FSW_MAX) ||
          ((w[`EXP_MSB:`EXP_LSB] == `EXP_1) &&
          w[`MAN_MSB:0] >= `FSW_MIN_E1 && w[`MAN_MSB:0] <= `FSW_MAX_E1);
        `S_VINON, `S_VINOFF, `S_IOFS:
          legal = (w[`EXP_MSB:`EXP_LSB] == `EXP_M1);
        // other slots take any value
        default: legal = 1'b1;
      endcase
    end
  endfunction

  // write guard: guard register itself always writable
  function allowed;
    input [7:0] g;
    input [7:0] c;
    begin
      if (g == `GUARD_ALL)
        allowed = (c == `CMD_GUARD);
      else if (g == `GUARD_SOME)
        allowed = (c == `CMD_GUARD) || (c == `CMD_RUN);
      else if (g == `GUARD_RUNONLY)
        allowed = (c == `CMD_GUARD) || (c == `CMD_RUN) || (c == `CMD_ONSRC);
      // zero or unknown guard values protect nothing
      else
        allowed = 1'b1;
    end
  endfunction

  // code decode, shared by the write and read paths
  cmd_table u_table (
    .code(code),
    .slot(slot),
    .is_word(is_word),
    .is_send(is_send)
  );

  // clamp comes after trim, so no setting can escape the ceiling
  vout_target u_goal (
    .setpoint(regs[`S_SETPT]),
    .trim(regs[`S_TRIM]),
    .margin_hi(regs[`S_MHI]),
    .margin_lo(regs[`S_MLO]),
    .ceiling(regs[`S_CEIL]),
    .margin_sel(regs[`S_RUN][`MARG_MSB:`MARG_LSB]),
    .target(goal)
  );

  // register store: reset defaults, bus writes, otp restore
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      localparam [4:0] SLOT = gi; // slot number of this word
      // restore wins; bus writes are only taken while idle
      always @(posedge ref_clk) begin
        if (!rst_b)
          regs[gi] <= dflt(SLOT);
        else if (state == ST_LOAD && seq_cnt == SLOT)
          regs[gi] <= otp_rdata;
        else if (state == ST_IDLE && data_valid && slot == SLOT &&
          allowed(regs[`S_GUARD][7:0], code)) begin
          if (!is_word && nbytes == 2'd0)
            regs[gi] <= {8'h00, data_byte};
          else if (is_word && nbytes == 2'd1 && legal(SLOT, wr_word))
            regs[gi] <= wr_word;
        end
      end
    end
  endgenerate

  // frame tracking, read byte order, send-byte commands
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      // idle, empty and quiet in reset
      state <= ST_IDLE;
      code <= 8'h00;
      nbytes <= 2'd0;
      lo_byte <= 8'h00;
      rd_hi <= 1'b0;
      seq_cnt <= 5'h00;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      fault_latch <= 16'h0000;
      otp_burn <= 1'b0;
      otp_we <= 1'b0;
      otp_addr <= 5'h00;
      otp_wdata <= 16'h0000;
      busy <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      // strobes drop after one cycle unless renewed below
      rd_valid <= 1'b0;
      otp_we <= 1'b0;
      otp_burn <= 1'b0;
      cmd_error <= 1'b0;
      // new fault events win over a clear in the same cycle
      fault_latch <= fault_events | ((state == ST_IDLE && frame_stop &&
        code == `CMD_CLRFLT && nbytes == 2'd0) ? 16'h0000 : fault_latch);
      // a new start also ends a frame cut short by a timeout
      if (frame_start) begin
        nbytes <= 2'd0;
        rd_hi <= 1'b0;
      end
      // code kept until the next code byte
      if (code_valid)
        code <= code_byte;
      if (data_valid) begin
        // low byte first; a word commits in the store on the second, a byte on the first
        if (nbytes == 2'd0)
          lo_byte <= data_byte;
        if (nbytes != 2'd3)
          nbytes <= nbytes + 2'd1;
        // bytes the guard blocks or with no slot are flagged; the store just ignores them
        if (!allowed(regs[`S_GUARD][7:0], code) || slot == `S_NONE)
          cmd_error <= 1'b1;
      end
      // answer one cycle after the request, low half first
      if (rd_req) begin
        rd_valid <= 1'b1;
        rd_hi <= ~rd_hi;
        if (code == `CMD_FEAT)
          rd_data <= `FEAT_VAL;
        else if (slot == `S_NONE)
          rd_data <= 8'h00;
        else if (rd_hi)
          rd_data <= regs[slot][15:8];
        else
          rd_data <= regs[slot][7:0];
      end
      // store and restore sequencer
      case (state)
        ST_IDLE: begin
          // send bytes act only on a clean stop with no data
          if (frame_stop && is_send && nbytes == 2'd0) begin
            if (code == `CMD_STORE && allowed(regs[`S_GUARD][7:0], code)) begin
              state <= ST_STORE;
              busy <= 1'b1;
              seq_cnt <= 5'h00;
            end else if (code == `CMD_RESTORE) begin
              // restore is never guarded, so a locked part can recover
              state <= ST_LOAD;
              busy <= 1'b1;
              seq_cnt <= 5'h00;
              otp_addr <= 5'h00;
            end
          end
        end
        ST_STORE: begin
          // one word per cycle, burn with the last word, then wait for otp
          if (seq_cnt < NREG) begin
            otp_we <= 1'b1;
            otp_addr <= seq_cnt;
            otp_wdata <= regs[seq_cnt];
            seq_cnt <= seq_cnt + 5'h01;
            // burn rides with the last word so otp can start at once
            if (seq_cnt == NREG - 1)
              otp_burn <= 1'b1;
          end else if (otp_done) begin
            // busy holds until otp reports the burn done
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        ST_LOAD: begin
          // otp read assumed combinational on otp_addr
          if (seq_cnt == NREG - 1) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end else begin
            // address and slot step together
            seq_cnt <= seq_cnt + 5'h01;
            otp_addr <= seq_cnt + 5'h01;
          end
        end
        // a broken one-hot code falls back to idle
        default: state <= ST_IDLE;
      endcase
    end
  end

  // registered copies of configuration for the power stage
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      // power stage sees zeros while held in reset
      conv_on <= 1'b0;
      vout_goal <= 16'h0000;
      onsrc_cfg <= 8'h00;
      slew_cfg <= 16'h0000;
      scale_cfg <= 16'h0000;
      fsw_cfg <= 16'h0000;
      vin_on_cfg <= 16'h0000;
      vin_off_cfg <= 16'h0000;
      iout_ofs_cfg <= 16'h0000;
      ov_fault_cfg <= 16'h0000;
      ov_shutdown <= 1'b0;
      ov_warn_cfg <= 16'h0000;
      alert_active <= 16'h0000;
    end else begin
      // copies lag the store by one cycle
      conv_on <= regs[`S_RUN][`ON_BIT];
      vout_goal <= goal;
      onsrc_cfg <= regs[`S_ONSRC][7:0];
      slew_cfg <= regs[`S_SLEW];
      scale_cfg <= regs[`S_SCALE];
      fsw_cfg <= regs[`S_FSW];
      vin_on_cfg <= regs[`S_VINON];
      vin_off_cfg <= regs[`S_VINOFF];
      iout_ofs_cfg <= regs[`S_IOFS];
      ov_fault_cfg <= regs[`S_OVF];
      ov_shutdown <= regs[`S_OVACT][`OVACT_SHUT_BIT];
      ov_warn_cfg <= regs[`S_OVW];
      // masked faults never reach the alert line
      alert_active <= fault_latch & ~regs[`S_AMASK];
    end
  end
endmodule // pmbus_command_set

// *** pmbus_command_set_asserts.sv ***
`timescale 1ns/1ps
// port-level checker for the command decoder
module pmbus_command_set_asserts (
  input wire ref_clk,
  input wire rst_b,
  input wire frame_start,
  input wire code_valid,
  input wire [7:0] code_byte,
  input wire data_valid,
  input wire [7:0] data_byte,
  input wire frame_stop,
  input wire rd_req,
  input wire [15:0] fault_events,
  input wire [7:0] rd_data,
  input wire rd_valid,
  input wire [15:0] fault_latch,
  input wire [15:0] alert_active,
  input wire otp_burn,
  input wire [4:0] otp_addr,
  input wire otp_we,
  input wire busy
);
  reg [7:0] last_code; // code of the current frame
  reg [7:0] guard; // shadow of the guard byte
  reg [1:0] rd_n; // reads since frame start
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // shadow state, so a refused store is not taken for a fault
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      last_code <= 8'h00;
      guard <= 8'h00;
      rd_n <= 2'h0;
    end else begin
      if (code_valid) last_code <= code_byte;
      if (data_valid && last_code == 8'h10) guard <= data_byte;
      if (frame_start) rd_n <= 2'h0;
      else if (rd_req && rd_n != 2'h3) rd_n <= rd_n + 2'h1;
    end
  end
  chk_read_answer: assert property (rd_req |=> rd_valid)
    else $error("read request got no answer");
  chk_read_cause: assert property (rd_valid |-> $past(rd_req))
    else $error("read answer without request");
  chk_feature_nibble: assert property (rd_valid && last_code == 8'h19 && rd_n == 2'h1
    |-> rd_data[7:4] == 4'hB) else $error("capability nibble wrong");
  chk_alert_gated: assert property ((alert_active & ~$past(fault_latch)) == 16'h0000)
    else $error("alert without latched fault");
  chk_clear_faults: assert property (code_valid && code_byte == 8'h03 && guard == 8'h00
    ##1 frame_stop && fault_events == 16'h0000 |-> ##[1:3] fault_latch == 16'h0000)
    else $error("faults not cleared");
  chk_store_start: assert property (code_valid && code_byte == 8'h15 && guard == 8'h00
    ##1 frame_stop && !busy |-> ##[1:2] busy) else $error("store did not start");
  chk_burn_last: assert property (otp_burn |-> otp_we && otp_addr == 5'h12)
    else $error("burn not with last slot");
  chk_we_busy: assert property (otp_we |-> busy)
    else $error("otp write while idle");
  chk_restore_walk: assert property (code_valid && code_byte == 8'h16 && guard == 8'h00
    ##1 frame_stop && !busy |-> ##[1:2] busy ##[17:24] !busy)
    else $error("restore walk length wrong");
  // main scenarios reached
  cover property (otp_burn);
  cover property (rd_valid && last_code == 8'h19);
  cover property (fault_latch != 16'h0000 ##1 fault_latch == 16'h0000);
endmodule // pmbus_command_set_asserts
bind pmbus_command_set pmbus_command_set_asserts i_pmbus_command_set_asserts (.*);

// *** host_model.sv ***
`timescale 1ns/1ps
// bus host: frames transactions toward the decoder, one byte a pulse
module host_model (
  input wire ref_clk,
  input wire rd_valid,
  input wire [7:0] rd_data,
  output reg frame_start,
  output reg code_valid,
  output reg [7:0] code_byte,
  output reg data_valid,
  output reg [7:0] data_byte,
  output reg frame_stop,
  output reg rd_req
);
  // idle bus at time zero
  initial begin
    {frame_start, code_valid, data_valid, frame_stop, rd_req} = 5'h00;
    code_byte = 8'h00;
    data_byte = 8'h5A;
  end
  // frame start then command code
  task open_frame(input logic [7:0] c);
    @(negedge ref_clk) frame_start = 1'b1;
    @(negedge ref_clk) frame_start = 1'b0;
    code_valid = 1'b1;
    code_byte = c;
    @(negedge ref_clk) code_valid = 1'b0;
    code_byte = ~c; // stale code must not be relied on
  endtask
  // write, low byte first, commit only after the whole unit
  task wr(input logic [7:0] c, input logic [1:0] n, input logic [15:0] w);
    open_frame(c);
    data_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      data_byte = w[8*i+:8];
      @(negedge ref_clk);
    end
    data_valid = 1'b0;
    data_byte = ~data_byte;
    frame_stop = 1'b1;
    @(negedge ref_clk) frame_stop = 1'b0;
  endtask
  // read, low byte first; unanswered bytes come back unknown
  task rd(input logic [7:0] c, input logic [1:0] n, output logic [15:0] v);
    open_frame(c);
    v = 16'hXXXX;
    for (int i = 0; i < n; i++) begin
      rd_req = 1'b1;
      @(negedge ref_clk) rd_req = 1'b0;
      if (rd_valid === 1'b1) v[8*i+:8] = rd_data;
      @(negedge ref_clk);
    end
    frame_stop = 1'b1;
    @(negedge ref_clk) frame_stop = 1'b0;
  endtask
  // frame cut after one data byte, as a bus timeout leaves it
  task cut(input logic [7:0] c, input logic [7:0] b);
    open_frame(c);
    data_valid = 1'b1;
    data_byte = b;
    @(negedge ref_clk) data_valid = 1'b0;
  endtask
  // send byte: code only, acted on at the stop
  task send(input logic [7:0] c);
    open_frame(c);
    frame_stop = 1'b1;
    @(negedge ref_clk) frame_stop = 1'b0;
  endtask
endmodule // host_model

// *** pmbus_command_set_test.sv ***
`timescale 1ns/1ps
// self-checking bench for the command decoder
module pmbus_command_set_test;
  wire frame_start, code_valid, data_valid, frame_stop, rd_req, rd_valid, otp_burn, otp_we;
  wire busy, cmd_error, conv_on, ov_shutdown;
  wire [7:0] code_byte, data_byte, rd_data, onsrc_cfg;
  wire [4:0] otp_addr;
  wire [15:0] fault_latch, alert_active, otp_wdata, vout_goal, slew_cfg, scale_cfg, fsw_cfg;
  wire [15:0] vin_on_cfg, vin_off_cfg, iout_ofs_cfg, ov_fault_cfg, ov_warn_cfg;
  logic ref_clk = 1'b0; // 250 MHz
  logic rst_b = 1'b0; // sync, active low
  logic [15:0] fault_events = 16'h0000; // fault sets
  logic otp_done = 1'b0; // burn finished
  logic [15:0] otp_mem [32]; // stand-in otp array
  logic err_seen = 1'b0; // sticky copy of cmd_error
  wire [15:0] otp_rdata = otp_mem[otp_addr]; // combinational otp read
  int error_cnt = 0;
  int checks = 0;
  int i;
  logic [15:0] v;
  logic [7:0] c;
  // code, written value, reset default
  logic [39:0] rows [17] = '{40'h0100A00080, 40'h0200170016, 40'h1B00FF0000, 40'h2101800200,
    40'h2200100000, 40'h2403800400, 40'h2502300219, 40'h2601D001E6, 40'h27E004E002,
    40'h29E804E808, 40'h3303E803D2, 40'h35F812F810, 40'h36F80CF80E, 40'h39F8010000,
    40'h4002A002CB, 40'h4100000080, 40'h420280029A};
  // code, illegal value, value that must remain
  logic [39:0] bad [4] = '{40'h29E803E804, 40'h3305DD03E8, 40'h27D801E004, 40'h35F010F812};
  pmbus_command_set i_pmbus_command_set (.*);
  host_model i_host_model (.*);
  initial forever #2 ref_clk = ~ref_clk;
  // otp side: array writes, done one cycle after the burn strobe
  always @(negedge ref_clk) begin
    if (otp_we) otp_mem[otp_addr] <= otp_wdata;
    otp_done <= otp_burn;
  end
  // refusals are pulses, so keep a sticky copy
  always @(posedge ref_clk) if (cmd_error === 1'b1) err_seen <= 1'b1;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function logic [1:0] width(input logic [7:0] cc);
    width = (cc == 8'h01 || cc == 8'h02 || cc == 8'h10 || cc == 8'h41) ? 2'h1 : 2'h2;
  endfunction
  // write, read back, compare
  task do_row(input logic [7:0] cc, input logic [15:0] w, input logic [15:0] e);
    i_host_model.wr(cc, width(cc), w);
    i_host_model.rd(cc, width(cc), v);
    if (width(cc) == 2'h1) v[15:8] = 8'h00;
    chk(v, e);
  endtask
  task do_reset();
    rst_b = 1'b0;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
  // bounded wait for the otp walk to finish
  task wait_idle();
    repeat (3) @(negedge ref_clk);
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge ref_clk);
    chk({15'h0000, busy}, 16'h0000);
  endtask
  task stop_test();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog well past the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    for (int k = 0; k < 32; k++) otp_mem[k] = 16'h0000;
    @(negedge ref_clk);
    do_reset();
    for (i = 0; i < 17; i++) do_row(rows[i][39:32], rows[i][31:16], rows[i][31:16]);
    for (i = 0; i < 4; i++) do_row(bad[i][39:32], bad[i][31:16], bad[i][15:0]);
    repeat (3) @(negedge ref_clk);
    chk(vout_goal, 16'h0240);
    chk(fsw_cfg, 16'h03E8);
    do_row(8'h33, 16'h09F4, 16'h09F4);
    chk({8'h00, onsrc_cfg}, 16'h0017);
    chk({15'h0000, conv_on}, 16'h0001);
    i_host_model.send(8'h15);
    wait_idle();
    // a second reset brings back every default
    do_reset();
    for (i = 0; i < 17; i++) begin
      c = rows[i][39:32];
      i_host_model.rd(c, width(c), v);
      if (width(c) == 2'h1) v[15:8] = 8'h00;
      chk(v, rows[i][15:0]);
    end
    i_host_model.rd(8'h19, 2'h1, v);
    chk({12'h000, v[7:4]}, 16'h000B);
    chk(vout_goal, 16'h0200);
    chk({15'h0000, ov_shutdown}, 16'h0001);
    chk(slew_cfg, 16'hE002);
    chk(scale_cfg, 16'hE808);
    chk(vin_on_cfg, 16'hF810);
    chk(vin_off_cfg, 16'hF80E);
    chk(iout_ofs_cfg, 16'h0000);
    chk(ov_fault_cfg, 16'h02CB);
    chk(ov_warn_cfg, 16'h029A);
    i_host_model.send(8'h16);
    wait_idle();
    i_host_model.rd(8'h21, 2'h2, v);
    chk(v, 16'h0180);
    // nominal target plus trim, above the ceiling
    i_host_model.wr(8'h01, 2'h1, 16'h0080);
    i_host_model.cut(8'h21, 8'h44);
    i_host_model.wr(8'h21, 2'h2, 16'h0500);
    i_host_model.rd(8'h21, 2'h2, v);
    chk(v, 16'h0500);
    repeat (3) @(negedge ref_clk);
    chk(vout_goal, 16'h0380);
    // margin low with a negative trim
    i_host_model.wr(8'h01, 2'h1, 16'h0090);
    i_host_model.wr(8'h22, 2'h2, 16'hFFF0);
    repeat (3) @(negedge ref_clk);
    chk(vout_goal, 16'h01C0);
    fault_events = 16'h0104;
    @(negedge ref_clk) fault_events = 16'h0000;
    repeat (3) @(negedge ref_clk);
    chk(fault_latch, 16'h0104);
    chk(alert_active, 16'h0100);
    i_host_model.send(8'h03);
    repeat (3) @(negedge ref_clk);
    chk(fault_latch, 16'h0000);
    // guard levels 80, 40 block the config byte, 20 lets it through
    for (i = 0; i < 3; i++) begin
      i_host_model.wr(8'h10, 2'h1, {8'h00, 8'h80 >> i});
      err_seen = 1'b0;
      i_host_model.wr(8'h02, 2'h1, 16'h001E);
      i_host_model.rd(8'h02, 2'h1, v);
      chk({8'h00, v[7:0]}, (i == 2) ? 16'h001E : 16'h0017);
      chk({15'h0000, err_seen}, (i == 2) ? 16'h0000 : 16'h0001);
    end
    i_host_model.wr(8'h10, 2'h1, 16'h0000);
    err_seen = 1'b0;
    i_host_model.wr(8'h30, 2'h1, 16'h0000); // unknown code is refused
    repeat (2) @(negedge ref_clk);
    chk({15'h0000, err_seen}, 16'h0001);
    stop_test();
  end
endmodule // pmbus_command_set_test
